// ===== include/scr_map.svh
// Register offsets, field positions, reset values and rates of the control registers
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// Register byte offsets inside the register window
`define SCR_OFS_HALT 8'h60
`define SCR_OFS_DMASTAT 8'h70
`define SCR_OFS_DSPCTL 8'h80
`define SCR_OFS_DSPPROG 8'h84
`define SCR_OFS_DSPPTR 8'h88
`define SCR_OFS_DSPDATA 8'h8c
`define SCR_OFS_T0CMP 8'h90
`define SCR_OFS_T1RLD 8'h94
`define SCR_OFS_T1MODE 8'h98
`define SCR_OFS_MASK 8'ha0
`define SCR_OFS_PEND 8'ha4
`define SCR_OFS_ACK 8'ha8
`define SCR_OFS_SET0 8'hb0
`define SCR_OFS_SET1 8'hb4
`define SCR_OFS_REFR 8'hb8

// Forced halt command bit
`define SCR_HALT_BIT 0

// Transfer condition fields
`define SCR_ST_DSP_ACT 0
`define SCR_ST_DSP_STBY 1
`define SCR_ST_L0_ACT 4
`define SCR_ST_L0_STBY 5
`define SCR_ST_L1_ACT 8
`define SCR_ST_L1_STBY 9
`define SCR_ST_L2_ACT 12
`define SCR_ST_L2_STBY 13
`define SCR_ST_L0_INTR 16
`define SCR_ST_L1_INTR 17
`define SCR_ST_ABUS 20
`define SCR_ST_BBUS 21
`define SCR_ST_DSPBUS 22

// Program control fields
`define SCR_DSP_PC_LSB 0
`define SCR_DSP_LOAD 15
`define SCR_DSP_EXEC 16
`define SCR_DSP_STEP 17
`define SCR_DSP_END 18
`define SCR_DSP_OVF 19
`define SCR_DSP_CARRY 20
`define SCR_DSP_ZERO 21
`define SCR_DSP_SIGN 22
`define SCR_DSP_DBUS 23
`define SCR_DSP_PAUSE 25
`define SCR_DSP_RESUME 26

// Line timer mode fields
`define SCR_T1_ON 0
`define SCR_T1_SEL 8

// Refresh fields
`define SCR_REFR_WAIT_LSB 0
`define SCR_REFR_EN 4
`define SCR_REFR_W 5

// Acknowledge enable bit
`define SCR_ACK_BIT 0

// Space settings: two spaces per 32-bit word, one half word each
`define SCR_SPACE_W 15
`define SCR_SPACE_LO 0
`define SCR_SPACE_HI 16
`define SCR_SET_RMASK 32'h7fff7fff

// Pending bits owned by the two timers
`define SCR_IRQ_T0 3
`define SCR_IRQ_T1 4

// Reset values
`define SCR_MASK_RST 14'h3fff

// Clock and line timer rates in kHz
`define SCR_CLK_KHZ 25000
`define SCR_T1_KHZ 7000

`endif

// ===== include/scr_pkg.sv
// Types shared by the control register block and its neighbours
package scr_pkg;

  // Live condition of the transfer engine
  typedef struct packed {
    logic [2:0] lvl_standby;
    logic [2:0] lvl_active;
    logic dsp_standby;
    logic dsp_active;
    logic dsp_bus;
    logic b_bus;
    logic a_bus;
    logic [1:0] lvl_intr;
  } scr_dma_state_t;

  // Flags reported by the signal processor core
  typedef struct packed {
    logic end_irq;
    logic dma_bus;
    logic sign;
    logic zero;
    logic carry;
    logic ovf;
  } scr_dsp_flags_t;

  // Commands to the signal processor core
  typedef struct packed {
    logic run;
    logic step;
    logic load;
    logic pause;
    logic resume;
    logic [7:0] pc;
  } scr_dsp_cmd_t;

  // Memory write toward the signal processor
  typedef struct packed {
    logic prog_we;
    logic data_we;
    logic [31:0] wdata;
  } scr_dsp_wr_t;

  // Settings of one external bus space
  typedef struct packed {
    logic read_ahead;
    logic pre_wr;
    logic pre_rd;
    logic ext_wait;
    logic [3:0] burst_wait;
    logic [3:0] single_wait;
    logic [1:0] burst_len;
    logic bus8;
  } scr_space_cfg_t;

endpackage

// ===== rtl/scr_regs.sv
// Control and status register bank of the system controller
`timescale 1ns/1ns
`default_nettype none
`include "scr_map.svh"

// Operation
// - Halt bit stops transfers at once
// - Halted transfers stay unusable until reset
// - Standby and active flags per level
// - Flags for DSP, B and A bus access
// - Interrupted flags for levels 0 and 1
// - Program port: addresses and core flags
// - Execute, step and counter load bits
// - Pause and resume commands, zero ignored
// - Program words go to program memory
// - Pointer holds the data memory address
// - Data port writes and reads memory
// - Frame timer interrupts on compare match
// - Line timer reloads, counts 7 MHz, fires
// - Operation bit enables, selects timing
// - Mask bit one suppresses that interrupt
// - Pending read shows occurred sources
// - Writing zero clears, one keeps
// - Acknowledge enable bit, read and write
// - Per-space enable bits, one enables
// - Per-space wait counts and burst length
// - Bus width bit, one means 8-bit
// - Refresh output enable and wait count
module scr_regs #(
  parameter int NIRQ = 14,
  parameter int T0_W = 10,
  parameter int T1_W = 9,
  parameter int PTR_W = 8,
  parameter int CLK_KHZ = `SCR_CLK_KHZ,
  parameter int T1_KHZ = `SCR_T1_KHZ
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire scr_pkg::scr_dma_state_t dma_state_i,
  output logic dma_halt_o,
  input wire scr_pkg::scr_dsp_flags_t dsp_flags_i,
  input wire logic [31:0] dsp_rdata_i,
  output scr_pkg::scr_dsp_cmd_t dsp_cmd_o,
  output scr_pkg::scr_dsp_wr_t dsp_wr_o,
  output logic [PTR_W-1:0] dsp_ptr_o,
  input wire logic vblank_in_i,
  input wire logic hblank_in_i,
  input wire logic [NIRQ-1:0] irq_src_i,
  output logic irq_o,
  output logic ack_en_o,
  output scr_pkg::scr_space_cfg_t [3:0] space_cfg_o,
  output logic refresh_en_o,
  output logic [3:0] refresh_wait_o
);

  // Elaboration checks on the parameters
  initial begin
    if (NIRQ != 14) $error("scr_regs: NIRQ must be 14");
    if (T0_W < 1 || T0_W > 16) $error("scr_regs: T0_W out of range");
    if (T1_W < 1 || T1_W > 16) $error("scr_regs: T1_W out of range");
    if (PTR_W < 1 || PTR_W > 32) $error("scr_regs: PTR_W out of range");
    if (T1_KHZ >= CLK_KHZ || T1_KHZ < 1) $error("scr_regs: T1_KHZ must be below CLK_KHZ");
  end

  // Accumulator holds the clock rate plus one step without wrapping early
  localparam int ACC_W = $clog2(CLK_KHZ + 1) + 1;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(T1_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);

  // One-hot write select for a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Write decode
  wire wr_halt = wr_i && hit(addr_i, `SCR_OFS_HALT);
  wire wr_dspctl = wr_i && hit(addr_i, `SCR_OFS_DSPCTL);
  wire wr_prog = wr_i && hit(addr_i, `SCR_OFS_DSPPROG);
  wire wr_ptr = wr_i && hit(addr_i, `SCR_OFS_DSPPTR);
  wire wr_data = wr_i && hit(addr_i, `SCR_OFS_DSPDATA);
  wire wr_t0 = wr_i && hit(addr_i, `SCR_OFS_T0CMP);
  wire wr_t1 = wr_i && hit(addr_i, `SCR_OFS_T1RLD);
  wire wr_mode = wr_i && hit(addr_i, `SCR_OFS_T1MODE);
  wire wr_mask = wr_i && hit(addr_i, `SCR_OFS_MASK);
  wire wr_pend = wr_i && hit(addr_i, `SCR_OFS_PEND);
  wire wr_ack = wr_i && hit(addr_i, `SCR_OFS_ACK);
  wire wr_set0 = wr_i && hit(addr_i, `SCR_OFS_SET0);
  wire wr_set1 = wr_i && hit(addr_i, `SCR_OFS_SET1);
  wire wr_refr = wr_i && hit(addr_i, `SCR_OFS_REFR);

  // Software-held state
  logic halted; // Sticky, only reset revives the engine
  logic [T0_W-1:0] t0_cmp;
  logic [T1_W-1:0] t1_rld;
  logic t1_on;
  logic t1_sel;
  logic [NIRQ-1:0] mask;
  logic [NIRQ-1:0] pend;
  logic [PTR_W-1:0] ptr;
  logic ack_en;
  logic [31:0] set0;
  logic [31:0] set1;
  logic [`SCR_REFR_W-1:0] refr; // Enable above the wait count

  // Timer state
  logic [T0_W-1:0] t0_cnt; // Lines since frame start
  logic [T1_W-1:0] t1_cnt;
  logic t1_armed; // One shot per line
  logic [ACC_W-1:0] acc; // Fractional 7 MHz divider
  logic tick;

  // Forced halt, sticky so the engine stays dead
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halted <= 1'b0;
    end else if (wr_halt && wdata_i[`SCR_HALT_BIT]) begin
      halted <= 1'b1;
    end
  end

  // Transfer halt output mirrors the sticky flag
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_halt_o <= 1'b0;
    end else begin
      dma_halt_o <= halted || (wr_halt && wdata_i[`SCR_HALT_BIT]);
    end
  end

  // Processor commands, single-cycle pulses except run and pc
  wire scr_pkg::scr_dsp_cmd_t next_cmd = '{
    run: wr_dspctl ? wdata_i[`SCR_DSP_EXEC] : dsp_cmd_o.run,
    step: wr_dspctl && wdata_i[`SCR_DSP_STEP],
    load: wr_dspctl && wdata_i[`SCR_DSP_LOAD],
    pause: wr_dspctl && wdata_i[`SCR_DSP_PAUSE],
    resume: wr_dspctl && wdata_i[`SCR_DSP_RESUME],
    pc: wr_dspctl && wdata_i[`SCR_DSP_LOAD] ? wdata_i[`SCR_DSP_PC_LSB +: 8] : dsp_cmd_o.pc
  };

  // Command register toward the core
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dsp_cmd_o <= '0;
    end else begin
      dsp_cmd_o <= next_cmd;
    end
  end

  // Memory write pulses with their data
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dsp_wr_o <= '0;
    end else begin
      dsp_wr_o.prog_we <= wr_prog;
      dsp_wr_o.data_we <= wr_data;
      if (wr_prog || wr_data) begin
        dsp_wr_o.wdata <= wdata_i;
      end
    end
  end

  // Data memory pointer, steady across the following data access
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr <= '0;
    end else if (wr_ptr) begin
      ptr <= wdata_i[PTR_W-1:0];
    end
  end

  // Plain settings registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t0_cmp <= '0;
      t1_rld <= '0;
      t1_on <= 1'b0;
      t1_sel <= 1'b0;
      mask <= `SCR_MASK_RST;
      ack_en <= 1'b0;
      set0 <= '0;
      set1 <= '0;
      refr <= '0;
    end else begin
      if (wr_t0) t0_cmp <= wdata_i[T0_W-1:0];
      if (wr_t1) t1_rld <= wdata_i[T1_W-1:0];
      if (wr_mode) begin
        t1_on <= wdata_i[`SCR_T1_ON];
        t1_sel <= wdata_i[`SCR_T1_SEL];
      end
      if (wr_mask) mask <= wdata_i[NIRQ-1:0];
      if (wr_ack) ack_en <= wdata_i[`SCR_ACK_BIT];
      if (wr_set0) set0 <= wdata_i;
      if (wr_set1) set1 <= wdata_i;
      if (wr_refr) refr <= wdata_i[`SCR_REFR_W-1:0];
    end
  end

  // Settings outputs, each space takes one half word
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      space_cfg_o <= '0;
      ack_en_o <= 1'b0;
      refresh_en_o <= 1'b0;
      refresh_wait_o <= '0;
    end else begin
      // Top bit of each half word is unused and never reaches a space
      space_cfg_o[0] <= set0[`SCR_SPACE_LO +: `SCR_SPACE_W];
      space_cfg_o[1] <= set0[`SCR_SPACE_HI +: `SCR_SPACE_W];
      space_cfg_o[2] <= set1[`SCR_SPACE_LO +: `SCR_SPACE_W];
      space_cfg_o[3] <= set1[`SCR_SPACE_HI +: `SCR_SPACE_W];
      ack_en_o <= ack_en;
      refresh_en_o <= refr[`SCR_REFR_EN];
      refresh_wait_o <= refr[`SCR_REFR_WAIT_LSB +: 4];
    end
  end

  // Frame timer counts lines and restarts at vertical blank start
  wire t0_match = (t0_cnt == t0_cmp);
  wire t0_event = hblank_in_i && t0_match;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t0_cnt <= '0;
    end else if (vblank_in_i) begin
      t0_cnt <= '0;
    end else if (hblank_in_i) begin
      t0_cnt <= t0_cnt + 1'b1;
    end
  end

  // 7 MHz enable from the 25 MHz clock; jitter of one cycle is accepted
  wire [ACC_W-1:0] acc_sum = acc + ACC_STEP;
  wire acc_wrap = (acc_sum >= ACC_WRAP);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= '0;
      tick <= 1'b0;
    end else begin
      acc <= acc_wrap ? acc_sum - ACC_WRAP : acc_sum;
      tick <= acc_wrap;
    end
  end

  // Line timer fires at zero; select bit limits it to the compare line
  wire t1_zero = tick && t1_armed && (t1_cnt == '0);
  wire t1_line_ok = !t1_sel || t0_match;
  wire t1_event = t1_on && t1_zero && t1_line_ok;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t1_cnt <= '0;
      t1_armed <= 1'b0;
    end else if (!t1_on) begin
      t1_armed <= 1'b0;
    end else if (hblank_in_i) begin
      t1_cnt <= t1_rld;
      t1_armed <= 1'b1;
    end else if (tick && t1_armed) begin
      if (t1_cnt == '0) begin
        t1_armed <= 1'b0;
      end else begin
        t1_cnt <= t1_cnt - 1'b1;
      end
    end
  end

  // Pending flags: events set, written zero clears, set wins
  logic [NIRQ-1:0] events;
  always_comb begin
    events = irq_src_i;
    events[`SCR_IRQ_T0] = irq_src_i[`SCR_IRQ_T0] || t0_event;
    events[`SCR_IRQ_T1] = irq_src_i[`SCR_IRQ_T1] || t1_event;
  end
  wire [NIRQ-1:0] keep = wr_pend ? wdata_i[NIRQ-1:0] : {NIRQ{1'b1}};
  wire [NIRQ-1:0] next_pend = (pend & keep) | events;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= '0;
      irq_o <= 1'b0;
    end else begin
      pend <= next_pend;
      irq_o <= |(next_pend & ~mask);
    end
  end

  // Pointer output
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dsp_ptr_o <= '0;
    end else begin
      dsp_ptr_o <= wr_ptr ? wdata_i[PTR_W-1:0] : ptr;
    end
  end

  // Transfer condition word
  logic [31:0] st_word;
  always_comb begin
    st_word = '0;
    st_word[`SCR_ST_DSP_ACT] = dma_state_i.dsp_active;
    st_word[`SCR_ST_DSP_STBY] = dma_state_i.dsp_standby;
    st_word[`SCR_ST_L0_ACT] = dma_state_i.lvl_active[0];
    st_word[`SCR_ST_L0_STBY] = dma_state_i.lvl_standby[0];
    st_word[`SCR_ST_L1_ACT] = dma_state_i.lvl_active[1];
    st_word[`SCR_ST_L1_STBY] = dma_state_i.lvl_standby[1];
    st_word[`SCR_ST_L2_ACT] = dma_state_i.lvl_active[2];
    st_word[`SCR_ST_L2_STBY] = dma_state_i.lvl_standby[2];
    st_word[`SCR_ST_L0_INTR] = dma_state_i.lvl_intr[0];
    st_word[`SCR_ST_L1_INTR] = dma_state_i.lvl_intr[1];
    st_word[`SCR_ST_ABUS] = dma_state_i.a_bus;
    st_word[`SCR_ST_BBUS] = dma_state_i.b_bus;
    st_word[`SCR_ST_DSPBUS] = dma_state_i.dsp_bus;
  end

  // Program control read word with live core flags
  logic [31:0] ctl_word;
  always_comb begin
    ctl_word = '0;
    ctl_word[`SCR_DSP_PC_LSB +: 8] = dsp_cmd_o.pc;
    ctl_word[`SCR_DSP_EXEC] = dsp_cmd_o.run;
    ctl_word[`SCR_DSP_END] = dsp_flags_i.end_irq;
    ctl_word[`SCR_DSP_OVF] = dsp_flags_i.ovf;
    ctl_word[`SCR_DSP_CARRY] = dsp_flags_i.carry;
    ctl_word[`SCR_DSP_ZERO] = dsp_flags_i.zero;
    ctl_word[`SCR_DSP_SIGN] = dsp_flags_i.sign;
    ctl_word[`SCR_DSP_DBUS] = dsp_flags_i.dma_bus;
  end

  // Mode and acknowledge read words; unused bits read zero
  logic [31:0] mode_word;
  logic [31:0] ack_word;
  always_comb begin
    mode_word = '0;
    mode_word[`SCR_T1_ON] = t1_on;
    mode_word[`SCR_T1_SEL] = t1_sel;
    ack_word = '0;
    ack_word[`SCR_ACK_BIT] = ack_en;
  end

  // Read multiplexer; write-only and unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (addr_i)
      `SCR_OFS_DMASTAT: rd_mux = st_word;
      `SCR_OFS_DSPCTL: rd_mux = ctl_word;
      `SCR_OFS_DSPPTR: rd_mux = 32'(ptr);
      `SCR_OFS_DSPDATA: rd_mux = dsp_rdata_i;
      `SCR_OFS_T0CMP: rd_mux = 32'(t0_cmp);
      `SCR_OFS_T1RLD: rd_mux = 32'(t1_rld);
      `SCR_OFS_T1MODE: rd_mux = mode_word;
      `SCR_OFS_MASK: rd_mux = 32'(mask);
      `SCR_OFS_PEND: rd_mux = 32'(pend);
      `SCR_OFS_ACK: rd_mux = ack_word;
      `SCR_OFS_SET0: rd_mux = set0 & `SCR_SET_RMASK;
      `SCR_OFS_SET1: rd_mux = set1 & `SCR_SET_RMASK;
      `SCR_OFS_REFR: rd_mux = 32'(refr);
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0;
    end
  end

endmodule // scr_regs

`default_nettype wire

// ===== bench/scr_regs_props.sv
// Port assertions for the control register bank
`timescale 1ns/1ns
`default_nettype none
module scr_regs_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire scr_pkg::scr_dma_state_t dma_state_i,
  input wire logic dma_halt_o,
  input wire scr_pkg::scr_dsp_cmd_t dsp_cmd_o,
  input wire scr_pkg::scr_dsp_wr_t dsp_wr_o,
  input wire logic ack_en_o,
  input wire scr_pkg::scr_space_cfg_t [3:0] space_cfg_o,
  input wire logic refresh_en_o,
  input wire logic [3:0] refresh_wait_o
);
  // One clock domain, so defaults are given once
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Write not repeated next cycle, so a late setting is not overwritten
  sequence s_lone_wr(logic [7:0] ofs);
    wr_i && addr_i == ofs ##1 !(wr_i && addr_i == ofs);
  endsequence
  // Load command high for one cycle only
  sequence s_load_pulse;
    dsp_cmd_o.load ##1 !dsp_cmd_o.load;
  endsequence
  a_halt_on: assert property (wr_i && addr_i == 8'h60 && wdata_i[0] |=> dma_halt_o)
    else $error("halt output did not follow the halt write");
  a_halt_sticky: assert property (dma_halt_o |=> dma_halt_o)
    else $error("halt output dropped before reset");
  a_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_bus_flags: assert property (rd_i && addr_i == 8'h70 && $stable(dma_state_i) |=>
    rdata_o[22:20] == $past({dma_state_i.dsp_bus, dma_state_i.b_bus, dma_state_i.a_bus}))
    else $error("bus access flags read wrong");
  a_load_pulse: assert property (wr_i && addr_i == 8'h80 && wdata_i[15] ##1 !wr_i |->
    s_load_pulse)
    else $error("counter load pulse wrong");
  a_pause_cmd: assert property (wr_i && addr_i == 8'h80 |=>
    dsp_cmd_o.pause == $past(wdata_i[25]) && dsp_cmd_o.resume == $past(wdata_i[26]))
    else $error("pause or resume pulse wrong");
  a_prog_word: assert property (wr_i && addr_i == 8'h84 |=>
    dsp_wr_o.prog_we && dsp_wr_o.wdata == $past(wdata_i))
    else $error("program word not passed on");
  a_data_word: assert property (wr_i && addr_i == 8'h8c |=> dsp_wr_o.data_we && !dsp_wr_o.prog_we)
    else $error("data word strobe wrong");
  a_space_cfg: assert property (s_lone_wr(8'hb0) |=>
    space_cfg_o[0] == $past(wdata_i[14:0], 2) && space_cfg_o[1] == $past(wdata_i[30:16], 2))
    else $error("space settings not applied");
  a_refresh_cfg: assert property (s_lone_wr(8'hb8) |=>
    {refresh_en_o, refresh_wait_o} == $past(wdata_i[4:0], 2))
    else $error("refresh settings not applied");
  a_ack_bit: assert property (s_lone_wr(8'ha8) |=> ack_en_o == $past(wdata_i[0], 2))
    else $error("acknowledge enable not applied");
endmodule // scr_regs_props

bind scr_regs scr_regs_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .dma_state_i(dma_state_i), .dma_halt_o(dma_halt_o), .dsp_cmd_o(dsp_cmd_o),
  .dsp_wr_o(dsp_wr_o), .ack_en_o(ack_en_o), .space_cfg_o(space_cfg_o),
  .refresh_en_o(refresh_en_o), .refresh_wait_o(refresh_wait_o));
`default_nettype wire

// ===== bench/system_controller_control_registers_test.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ns
`default_nettype none
module system_controller_control_registers_test;
  // Clock, reset and register bus
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  // Neighbour side inputs
  scr_pkg::scr_dma_state_t dma_state_i = '0;
  scr_pkg::scr_dsp_flags_t dsp_flags_i = '0;
  logic [31:0] dsp_rdata_i = 32'h0;
  logic vblank_in_i = 1'b0;
  logic hblank_in_i = 1'b0;
  logic [13:0] irq_src_i = 14'h0;
  // Design outputs
  logic dma_halt_o, irq_o, ack_en_o, refresh_en_o;
  logic [3:0] refresh_wait_o;
  logic [7:0] dsp_ptr_o;
  scr_pkg::scr_dsp_cmd_t dsp_cmd_o;
  scr_pkg::scr_dsp_wr_t dsp_wr_o;
  scr_pkg::scr_space_cfg_t [3:0] space_cfg_o;
  // Counters and model state
  int mismatches = 0;
  int checked = 0;
  logic [31:0] v, w, pend, msk, src;
  logic [31:0] mdl [9];
  // Readable offsets and the bits each one keeps
  logic [7:0] rw_ofs [9] = '{8'h88, 8'h90, 8'h94, 8'h98, 8'ha0, 8'ha8, 8'hb0, 8'hb4, 8'hb8};
  logic [31:0] rw_msk [9] = '{32'hff, 32'h3ff, 32'h1ff, 32'h101, 32'h3fff, 32'h1,
    32'h7fff7fff, 32'h7fff7fff, 32'h1f};
  // Write-only and unused places, all read as zero
  logic [7:0] dead_ofs [6] = '{8'h60, 8'h84, 8'h9c, 8'hac, 8'hbc, 8'h00};
  // Line timer modes: free, tied to a line that never comes, off
  logic [31:0] t1_modes [3] = '{32'h1, 32'h101, 32'h0};

  scr_regs DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dma_state_i(dma_state_i),
    .dma_halt_o(dma_halt_o), .dsp_flags_i(dsp_flags_i), .dsp_rdata_i(dsp_rdata_i),
    .dsp_cmd_o(dsp_cmd_o), .dsp_wr_o(dsp_wr_o), .dsp_ptr_o(dsp_ptr_o),
    .vblank_in_i(vblank_in_i), .hblank_in_i(hblank_in_i), .irq_src_i(irq_src_i),
    .irq_o(irq_o), .ack_en_o(ack_en_o), .space_cfg_o(space_cfg_o),
    .refresh_en_o(refresh_en_o), .refresh_wait_o(refresh_wait_o));

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Compare one result with the model
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One write cycle; ends where one-cycle effects stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  // One read cycle; data sampled mid-cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
  endtask
  // Blank start pulses, one cycle each
  task automatic hb();
    @(posedge clk_sys_i);
    hblank_in_i <= 1'b1;
    @(posedge clk_sys_i);
    hblank_in_i <= 1'b0;
  endtask
  task automatic vb();
    @(posedge clk_sys_i);
    vblank_in_i <= 1'b1;
    @(posedge clk_sys_i);
    vblank_in_i <= 1'b0;
  endtask
  // Expected transfer condition word
  function automatic logic [31:0] st_exp(input scr_pkg::scr_dma_state_t s);
    logic [31:0] e;
    e = 32'h0;
    for (int l = 0; l < 3; l++) begin
      e[4 + 4 * l] = s.lvl_active[l];
      e[5 + 4 * l] = s.lvl_standby[l];
    end
    e[1:0] = {s.dsp_standby, s.dsp_active};
    e[17:16] = s.lvl_intr;
    e[22:20] = {s.dsp_bus, s.b_bus, s.a_bus};
    return e;
  endfunction
  // Verdict and end of run
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    results();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h0b01e511));
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(8'ha0, v);
    chk("mask reset", 32'h3fff, v);
    rd(8'ha4, v);
    chk("pending reset", 32'h0, v);
    wr(8'h9c, $urandom);
    for (int i = 0; i < 6; i++) begin
      rd(dead_ofs[i], v);
      chk("dead read", 32'h0, v);
    end
    // Round trip through every readable setting
    for (int i = 0; i < 9; i++) begin
      w = $urandom;
      mdl[i] = w & rw_msk[i];
      wr(rw_ofs[i], w);
      rd(rw_ofs[i], v);
      chk("readback", mdl[i], v);
    end
    chk("pointer", mdl[0], dsp_ptr_o);
    chk("ack", mdl[5], ack_en_o);
    chk("spaces", {mdl[7][30:16], mdl[7][14:0], mdl[6][30:16], mdl[6][14:0]}, space_cfg_o);
    chk("refresh", mdl[8], {refresh_en_o, refresh_wait_o});
    // Live transfer condition
    for (int i = 0; i < 3; i++) begin
      w = $urandom;
      @(posedge clk_sys_i);
      dma_state_i <= w[12:0];
      rd(8'h70, v);
      chk("status", st_exp(dma_state_i), v);
    end
    // Core control and flags
    w = $urandom;
    @(posedge clk_sys_i);
    dsp_flags_i <= w[5:0];
    wr(8'h80, 32'h18000 | w[15:8]);
    chk("run load pc", {2'b11, w[15:8]}, {dsp_cmd_o.run, dsp_cmd_o.load, dsp_cmd_o.pc});
    @(negedge clk_sys_i);
    chk("load drop", 2'b10, {dsp_cmd_o.run, dsp_cmd_o.load});
    rd(8'h80, v);
    chk("flags", {dsp_flags_i.dma_bus, dsp_flags_i.sign, dsp_flags_i.zero, dsp_flags_i.carry, dsp_flags_i.ovf, dsp_flags_i.end_irq}, v[23:18]);
    for (int i = 0; i < 6; i++) begin
      w = $urandom & 32'h06030000;
      wr(8'h80, w);
      chk("commands", {w[16], w[17], w[25], w[26]}, {dsp_cmd_o.run, dsp_cmd_o.step, dsp_cmd_o.pause, dsp_cmd_o.resume});
    end
    // Program and data memory ports
    w = $urandom;
    wr(8'h84, w);
    chk("program word", {2'b10, w}, dsp_wr_o);
    src = $urandom;
    wr(8'h88, w & 32'hff);
    wr(8'h8c, src);
    chk("data word", {2'b01, src}, dsp_wr_o);
    chk("data address", w[7:0], dsp_ptr_o);
    @(posedge clk_sys_i);
    dsp_rdata_i <= src ^ w;
    rd(8'h8c, v);
    chk("data read", src ^ w, v);
    // Pending capture, masking and clear by zero
    wr(8'h98, 32'h0);
    pend = 32'h0;
    for (int i = 0; i < 6; i++) begin
      msk = $urandom & 32'h3fff;
      wr(8'ha0, msk);
      src = $urandom & 32'h3fff;
      @(posedge clk_sys_i);
      irq_src_i <= src[13:0];
      @(posedge clk_sys_i);
      irq_src_i <= 14'h0;
      pend = pend | src;
      rd(8'ha4, v);
      chk("pending", pend, v);
      chk("irq", |(pend & ~msk), irq_o);
      w = $urandom;
      wr(8'ha4, w);
      pend = pend & w & 32'h3fff;
      rd(8'ha4, v);
      chk("pending clear", pend, v);
    end
    // Line timer on, then off
    wr(8'h90, 32'h3ff);
    wr(8'h94, 32'h4);
    for (int m = 0; m < 3; m++) begin
      wr(8'h98, t1_modes[m]);
      wr(8'ha4, 32'h0);
      hb();
      repeat (30) @(posedge clk_sys_i);
      rd(8'ha4, v);
      chk("line timer", (m == 0) ? 32'h10 : 32'h0, v);
    end
    // Frame timer match on the third line
    wr(8'h90, 32'h2);
    wr(8'ha4, 32'h0);
    vb();
    hb();
    hb();
    rd(8'ha4, v);
    chk("frame early", 32'h0, v);
    hb();
    rd(8'ha4, v);
    chk("frame match", 32'h8, v);
    // Forced halt, sticky once set
    wr(8'h60, 32'h0);
    chk("halt idle", 1'b0, dma_halt_o);
    wr(8'h60, 32'h1);
    chk("halt", 1'b1, dma_halt_o);
    wr(8'h60, 32'h0);
    chk("halt sticky", 1'b1, dma_halt_o);
    results();
  end
endmodule // system_controller_control_registers_test
`default_nettype wire
